//--- design/emg_global_ctrl.sv
/*
  emg_global_ctrl: global control and request priority of the external memory
  interface, with its control register on AHB-Lite.
  Assumes the interface clock runs whenever software touches the registers and
  that mode set, refresh and dma requests are levels held until their done pulse.
*/
`timescale 1ns/1ps
module emg_global_ctrl
  import emg_pkg::*;
#(
  parameter bit WIDE_INSTANCE = 1'b1
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // external pins
  input  wire logic        yield_request_n_i,
  input  wire logic        async_ready_in_i,
  output logic             yield_acknowledge_n_o,
  output logic             access_pending_out_o,
  output logic             first_ext_clock_out_o,
  output logic             first_ext_clock_oe_o,
  output logic             second_ext_clock_out_o,
  output logic             second_ext_clock_oe_o,
  output logic             div4_aux_clock_out_o,
  output logic             div6_aux_clock_out_o,
  output logic             bus_release_o,
  // internal requesters
  input  wire logic        mrs_req_i,
  input  wire logic        refresh_req_i,
  input  wire logic        dma_req_i,
  input  wire logic        access_done_i,
  output logic [2:0]       grant_o
);
  typedef enum logic [1:0] {
    EMG_OWN     = 2'b00,
    EMG_DRAIN   = 2'b01,
    EMG_RELEASE = 2'b11,
    EMG_YIELDED = 2'b10
  } emg_yield_t;

  logic [31:0] ctrl;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        busy;
  logic [2:0]  cur_grant;
  logic [2:0]  arb_grant;
  emg_yield_t  ystate;
  logic [1:0]  div2_cnt;
  logic        clk_half;
  logic        clk_quarter;
  logic        clk_full_lvl;
  logic        second_src;
  logic        first_src;
  logic        yielded;
  logic        yield_req;
  logic [31:0] status_word;
  logic [31:0] arb_word;

  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
    addr_hit = (a[7:0] == off) && (a[31:8] == 24'h00_0000);
  endfunction : addr_hit

  // write takes effect at the data phase edge, so the slave never stalls
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= GCS_RESET;
    end else if (wr_pend && addr_hit({24'h00_0000, wr_addr}, GCS_OFFSET)) begin
      ctrl <= hwdata & GCS_WMASK;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // yield handshake: drain the access in progress, release, then acknowledge
  assign yield_req = !yield_request_n_i && !ctrl[YDIS_BIT];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ystate <= EMG_OWN;
    end else begin
      unique case (ystate)
        EMG_OWN: begin
          if (yield_req) begin
            ystate <= (busy && !access_done_i) ? EMG_DRAIN : EMG_RELEASE;
          end
        end
        EMG_DRAIN: begin
          if (access_done_i) begin
            ystate <= EMG_RELEASE;
          end
        end
        EMG_RELEASE: begin
          ystate <= EMG_YIELDED;
        end
        EMG_YIELDED: begin
          if (yield_request_n_i) begin
            ystate <= EMG_OWN;
          end
        end
      endcase
    end
  end

  assign yielded               = (ystate == EMG_YIELDED);
  assign yield_acknowledge_n_o = !yielded;
  assign bus_release_o         = (ystate == EMG_RELEASE) || yielded;

  emg_arbiter u_arb (
    .yield_req_i   (yield_req && (ystate == EMG_OWN)),
    .mrs_req_i     (mrs_req_i),
    .refresh_req_i (refresh_req_i),
    .dma_req_i     (dma_req_i),
    .grant_o       (arb_grant)
  );

  // hold a grant until its access completes; no new one while yielding
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_grant <= GRANT_NONE;
      busy      <= 1'b0;
    end else if (busy) begin
      if (access_done_i) begin
        busy      <= 1'b0;
        cur_grant <= GRANT_NONE;
      end
    end else if (ystate == EMG_OWN && arb_grant != GRANT_NONE
                 && arb_grant != GRANT_YIELD) begin
      busy      <= 1'b1;
      cur_grant <= arb_grant;
    end
  end

  assign grant_o = cur_grant;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      access_pending_out_o <= 1'b0;
    end else if (ctrl[MODE_BIT]) begin
      access_pending_out_o <= dma_req_i || mrs_req_i || refresh_req_i || busy;
    end else begin
      access_pending_out_o <= dma_req_i || mrs_req_i
                              || (busy && cur_grant != GRANT_REFRESH);
    end
  end

  // second clock rate sources; rate is meant to change once only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div2_cnt <= 2'h0;
    end else begin
      div2_cnt <= div2_cnt + 2'h1;
    end
  end

  assign clk_half    = div2_cnt[0];
  assign clk_quarter = div2_cnt[1];

  // full rate passes the interface clock itself; switching is not glitch free
  assign clk_full_lvl = clk_sys_i;

  always_comb begin
    unique case (ctrl[RATE_LO_BIT +: 2])
      RATE_FULL:    second_src = clk_full_lvl;
      RATE_HALF:    second_src = clk_half;
      RATE_QUARTER: second_src = clk_quarter;
      default:      second_src = clk_quarter;
    endcase
  end

  assign first_src = clk_full_lvl;

  // enable gates low, float bit drops the drive while yielded
  assign second_ext_clock_out_o = ctrl[E2_BIT] & second_src;
  assign second_ext_clock_oe_o  = !(yielded && ctrl[F2_BIT]);
  assign first_ext_clock_out_o  = ctrl[E1_BIT] & first_src;
  assign first_ext_clock_oe_o   = !(yielded && ctrl[F1_BIT]);

  emg_clkdiv #(.DIV(DIV4_COUNT), .IDLE_HIGH(1'b1)) u_div4 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .enable_i  (ctrl[C4_BIT] || !WIDE_INSTANCE),
    .clk_o     (div4_aux_clock_out_o)
  );

  emg_clkdiv #(.DIV(DIV6_COUNT), .IDLE_HIGH(1'b1)) u_div6 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .enable_i  (ctrl[C6_BIT] || !WIDE_INSTANCE),
    .clk_o     (div6_aux_clock_out_o)
  );

  always_comb begin
    status_word = ctrl;
    if (!WIDE_INSTANCE) begin
      status_word[C4_BIT] = 1'b0;
      status_word[C6_BIT] = 1'b0;
    end
    status_word[PEND_BIT] = access_pending_out_o;
    status_word[RDY_BIT]  = async_ready_in_i;
    status_word[REQ_BIT]  = yield_request_n_i;
    status_word[ACK_BIT]  = yield_acknowledge_n_o;
  end

  assign arb_word = {24'h00_0000, 1'b0, cur_grant, busy, 1'b0, ystate};

  // read data registered at the address phase; unmapped reads zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (addr_hit(haddr, GCS_OFFSET)) begin
        hrdata <= status_word;
      end else if (addr_hit(haddr, ARB_STATUS_OFFSET)) begin
        hrdata <= arb_word;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule : emg_global_ctrl

//--- design/emg_pkg.sv
/*
  emg_pkg: constants shared by the global control block of the external memory interface.
  Assumes a single 20 MHz interface clock and an AHB-Lite register bus.
*/
package emg_pkg;
  // register byte offsets
  localparam logic [7:0]  GCS_OFFSET        = 8'h00;
  localparam logic [7:0]  ARB_STATUS_OFFSET = 8'h04;
  // field positions of global_control_status
  localparam int          RATE_LO_BIT       = 18;
  localparam int          F2_BIT            = 17;
  localparam int          E2_BIT            = 16;
  localparam int          MODE_BIT          = 13;
  localparam int          PEND_BIT          = 11;
  localparam int          RDY_BIT           = 10;
  localparam int          REQ_BIT           = 9;
  localparam int          ACK_BIT           = 8;
  localparam int          YDIS_BIT          = 7;
  localparam int          F1_BIT            = 6;
  localparam int          E1_BIT            = 5;
  localparam int          C4_BIT            = 4;
  localparam int          C6_BIT            = 3;
  // writable bits
  localparam logic [31:0] GCS_WMASK         = 32'h000F_20F8;
  // reset value of the writable bits
  localparam logic [31:0] GCS_RESET         = 32'h0009_2078;
  // second clock rate encodings
  localparam logic [1:0]  RATE_FULL         = 2'h0;
  localparam logic [1:0]  RATE_HALF         = 2'h1;
  localparam logic [1:0]  RATE_QUARTER      = 2'h2;
  // auxiliary clock divisors
  localparam int          DIV4_COUNT        = 4;
  localparam int          DIV6_COUNT        = 6;
  // arbiter grant codes
  localparam logic [2:0]  GRANT_NONE        = 3'h0;
  localparam logic [2:0]  GRANT_YIELD       = 3'h1;
  localparam logic [2:0]  GRANT_MRS         = 3'h2;
  localparam logic [2:0]  GRANT_REFRESH     = 3'h3;
  localparam logic [2:0]  GRANT_DMA         = 3'h4;
  // cycles the bus outputs need to settle released before acknowledging
  localparam int          RELEASE_CYCLES    = 1;
endpackage : emg_pkg

//--- design/emg_clkdiv.sv
/*
  emg_clkdiv: divides the interface clock by an even count, gated by an enable.
  Assumes the enable comes from a register in the same clock domain.
*/
`timescale 1ns/1ps
module emg_clkdiv
  import emg_pkg::*;
#(
  parameter int DIV       = 4,
  parameter bit IDLE_HIGH = 1'b1
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  output logic      clk_o
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] HALF_M1 = CW'(DIV / 2 - 1);

  logic [CW-1:0] count;
  logic          phase;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (count == HALF_M1) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // a disabled divider parks at its idle level; restart may cut a pulse short
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= IDLE_HIGH;
    end else if (!enable_i) begin
      phase <= IDLE_HIGH;
    end else if (count == HALF_M1) begin
      phase <= ~phase;
    end
  end

  assign clk_o = phase;
endmodule : emg_clkdiv

//--- design/emg_arbiter.sv
/*
  emg_arbiter: fixed priority pick among yield, mode set, refresh and dma requests.
  Assumes all requests are levels held until served.
*/
`timescale 1ns/1ps
module emg_arbiter
  import emg_pkg::*;
(
  input  wire logic       yield_req_i,
  input  wire logic       mrs_req_i,
  input  wire logic       refresh_req_i,
  input  wire logic       dma_req_i,
  output logic [2:0]      grant_o
);
  always_comb begin
    if (yield_req_i) begin
      grant_o = GRANT_YIELD;
    end else if (mrs_req_i) begin
      grant_o = GRANT_MRS;
    end else if (refresh_req_i) begin
      grant_o = GRANT_REFRESH;
    end else if (dma_req_i) begin
      grant_o = GRANT_DMA;
    end else begin
      grant_o = GRANT_NONE;
    end
  end
endmodule : emg_arbiter

//--- verif/emg_properties.sv
/*
  emg_properties: port checks of the global control block.
  Assumes a bind onto emg_global_ctrl and one clock domain.
*/
`timescale 1ns/1ps
module emg_properties
  import emg_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       yield_request_n_i,
  input wire logic       yield_acknowledge_n_o,
  input wire logic       bus_release_o,
  input wire logic       first_ext_clock_oe_o,
  input wire logic       second_ext_clock_oe_o,
  input wire logic       access_pending_out_o,
  input wire logic       mrs_req_i,
  input wire logic       refresh_req_i,
  input wire logic       dma_req_i,
  input wire logic       access_done_i,
  input wire logic [2:0] grant_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_owned;
    !yield_acknowledge_n_o;
  endsequence
  sequence s_req_gone;
    $rose(yield_request_n_i);
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  AST_MRS_FIRST: assert property (grant_o == GRANT_REFRESH && $past(grant_o) == GRANT_NONE
    |-> !$past(mrs_req_i)) else $error("refresh granted over mode set");
  AST_DMA_LAST: assert property (grant_o == GRANT_DMA && $past(grant_o) == GRANT_NONE
    |-> !$past(mrs_req_i) && !$past(refresh_req_i)) else $error("dma granted too early");
  AST_ACK_CAUSE: assert property ($fell(yield_acknowledge_n_o) |-> !yield_request_n_i)
    else $error("acknowledge without request");
  AST_ACK_RELEASED: assert property (s_owned |-> bus_release_o)
    else $error("acknowledge with bus still driven");
  AST_ACK_DROP: assert property (s_owned ##0 s_req_gone |-> ##[1:2] yield_acknowledge_n_o)
    else $error("acknowledge kept after request left");
  AST_GRANT_HOLD: assert property (grant_o != GRANT_NONE && !access_done_i
    |=> grant_o == $past(grant_o)) else $error("grant moved before done");
  AST_FLOAT: assert property (!first_ext_clock_oe_o || !second_ext_clock_oe_o
    |-> bus_release_o) else $error("clock floated outside yield");
  AST_PEND_IDLE: assert property ((!mrs_req_i && !refresh_req_i && !dma_req_i)[*3]
    |-> !access_pending_out_o) else $error("pending with nothing requested");
endmodule : emg_properties

//--- verif/emg_partner.sv
/*
  emg_partner: external master that asks the interface to yield.
  Assumes the interface clock; owns the bus for OWN_CYCLES once acknowledged.
*/
`timescale 1ns/1ps
module emg_partner #(
  parameter int OWN_CYCLES = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic want_i,
  input  wire logic ack_n_i,
  output logic      req_n_o
);
  int cnt;
  // this master issues no direct peripheral transfers, so no fifo glue is needed
  // nor any dma set-up; width, address and count limits are kept by omission
  // request is held low until acknowledged, released only after owning the bus
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_n_o <= 1'b1;
      cnt     <= 0;
    end else if (req_n_o) begin
      if (want_i && ack_n_i) req_n_o <= 1'b0;
    end else if (!ack_n_i) begin
      cnt <= cnt + 1;
      if (cnt == OWN_CYCLES - 1) begin
        req_n_o <= 1'b1;
        cnt     <= 0;
      end
    end
  end
endmodule : emg_partner

//--- verif/test_emg_global_ctrl.sv
/*
  test_emg_global_ctrl: directed bench of the global control block.
  Assumes emg_pkg, emg_partner and emg_properties are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, (a), (e)); end end
module test_emg_global_ctrl
  import emg_pkg::*;
();
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, hsel = 1'b1, hwrite = 1'b0, want = 1'b0;
  logic        async_ready_in_i = 1'b1, access_done_i = 1'b0;
  logic        mrs_req_i = 1'b0, refresh_req_i = 1'b0, dma_req_i = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic        hreadyout, hresp, yield_request_n_i, yield_acknowledge_n_o, bus_release_o;
  logic        access_pending_out_o, first_ext_clock_out_o, first_ext_clock_oe_o;
  logic        second_ext_clock_out_o, second_ext_clock_oe_o;
  logic        div4_aux_clock_out_o, div6_aux_clock_out_o;
  logic [2:0]  grant_o;
  wire         hready = hreadyout;
  int          fail_count = 0, comparisons = 0, n1 = 0, n2 = 0, n4 = 0, n6 = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge first_ext_clock_out_o) n1++;
  always @(posedge second_ext_clock_out_o) n2++;
  always @(posedge div4_aux_clock_out_o) n4++;
  always @(posedge div6_aux_clock_out_o) n6++;

  emg_global_ctrl i_emg_global_ctrl (.*);
  emg_partner i_emg_partner (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .want_i(want),
    .ack_n_i(yield_acknowledge_n_o), .req_n_o(yield_request_n_i));

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  // pulses done while the request is still up, as the requesters must
  task automatic serve(input logic [2:0] g, input logic [2:0] nxt);
    repeat (2) @(posedge clk_sys_i);
    repeat (20) if (grant_o === GRANT_NONE) @(posedge clk_sys_i);
    `CHK(grant_o, g)
    access_done_i <= 1'b1;
    @(posedge clk_sys_i);
    access_done_i <= 1'b0;
    {mrs_req_i, refresh_req_i, dma_req_i} <= nxt;
    @(posedge clk_sys_i);
  endtask : serve

  // rate only moves faster, as start-up software would; edges may straddle a window
  task automatic t_rate;
    int s1, s2, s4, s6;
    for (int r = 2; r >= 0; r--) begin
      bus(1'b1, GCS_OFFSET, {GCS_RESET[31:20], r[1:0], GCS_RESET[17:0]});
      repeat (4) @(posedge clk_sys_i);
      s1 = n1;
      s2 = n2;
      s4 = n4;
      s6 = n6;
      repeat (24) @(posedge clk_sys_i);
      `CHK((n2 - s2) inside {[(24 >> r) - 1 : (24 >> r) + 1]}, 1'b1)
      `CHK((n1 - s1) inside {[23:25]}, 1'b1)
      `CHK((n4 - s4) inside {[5:7]}, 1'b1)
      `CHK((n6 - s6) inside {[3:5]}, 1'b1)
    end
  endtask : t_rate

  task automatic t_pend;
    {mrs_req_i, refresh_req_i, dma_req_i} <= 3'b111;
    serve(GRANT_MRS, 3'b011);
    serve(GRANT_REFRESH, 3'b001);
    serve(GRANT_DMA, 3'b000);
    refresh_req_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    `CHK(access_pending_out_o, 1'b1)
    rchk(GCS_OFFSET, 32'h0001_2F78);
    serve(GRANT_REFRESH, 3'b000);
    bus(1'b1, GCS_OFFSET, 32'h0001_0078);
    refresh_req_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    `CHK(access_pending_out_o, 1'b0)
    rchk(GCS_OFFSET, 32'h0001_0778);
    serve(GRANT_REFRESH, 3'b001);
    repeat (2) @(posedge clk_sys_i);
    `CHK(access_pending_out_o, 1'b1)
    serve(GRANT_DMA, 3'b000);
  endtask : t_pend

  task automatic t_yield;
    bus(1'b1, GCS_OFFSET, 32'h0003_20F8);
    want <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    `CHK(yield_acknowledge_n_o, 1'b1)
    rchk(GCS_OFFSET, 32'h0003_25F8);
    bus(1'b1, GCS_OFFSET, 32'h0003_2078);
    repeat (10) if (yield_acknowledge_n_o !== 1'b0) @(posedge clk_sys_i);
    want <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    `CHK({yield_acknowledge_n_o, first_ext_clock_oe_o, second_ext_clock_oe_o}, 3'b000)
    rchk(GCS_OFFSET, 32'h0003_2478);
    repeat (30) if (yield_acknowledge_n_o !== 1'b1) @(posedge clk_sys_i);
    `CHK({yield_acknowledge_n_o, bus_release_o}, 2'b10)
  endtask : t_yield

  task automatic t_regs;
    bus(1'b1, GCS_OFFSET, 32'hFFF1_FFFF);
    rchk(GCS_OFFSET, 32'h0001_27F8);
    async_ready_in_i <= 1'b0;
    bus(1'b1, GCS_OFFSET, 32'hFFF0_DF07);
    rchk(GCS_OFFSET, 32'h0000_0300);
    rchk(8'h08, 32'h0);
    repeat (12) begin
      @(posedge clk_sys_i);
      #1;
      `CHK({first_ext_clock_out_o, second_ext_clock_out_o, div4_aux_clock_out_o, div6_aux_clock_out_o}, 4'b0011)
    end
  endtask : t_regs

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rchk(GCS_OFFSET, 32'h0009_2778);
    t_rate();
    t_pend();
    t_yield();
    t_regs();
    finish_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #(3000 * 50);
    fail_count++;
    finish_test();
  end
endmodule : test_emg_global_ctrl

bind emg_global_ctrl emg_properties i_emg_properties (.*);
